// ---- common/psi_defs.svh ----
`ifndef PSI_DEFS_SVH
`define PSI_DEFS_SVH
// Register byte offsets
`define PSI_A_SEL      8'h00
`define PSI_A_ROT      8'h04
`define PSI_A_RELAY    8'h08
`define PSI_A_CAUSE    8'h0C
`define PSI_A_STATUS   8'h10
`define PSI_A_MASK     8'h14
`define PSI_A_STATE    8'h18
`define PSI_A_ALARM    8'h1C
// Interlock selection codes
`define PSI_SEL_OFF    2'h0
`define PSI_SEL_IN1    2'h1
`define PSI_SEL_IN2    2'h2
// Relay output selection value meaning staging
`define PSI_RELAY_STAGE 5'h1F
`define PSI_RELAY_W    5
// Rotation interval value meaning rotation off
`define PSI_ROT_OFF    32'h0000_0000
// Alarm code for a refused start
`define PSI_ALARM_CODE 32'h0000_07DF
// Status bit positions
`define PSI_ST_REFUSED 0
`define PSI_ST_CFGERR  1
`define PSI_ST_FAULT   2
// Relay count limits
`define PSI_CNT_MAX    3'h6
`define PSI_CNT_ZERO   3'h0
// Reset values and bus answers
`define PSI_ZERO32     32'h0000_0000
`define PSI_ALL_FREE   6'h3F
`define PSI_RESP_OKAY  2'h0
`define PSI_RESP_ERR   2'h2
`endif

// ---- common/psi_pkg.sv ----
package psi_pkg;
   // Result of the interlock mapping
   typedef struct packed {
      logic       speed_lock;
      logic [5:0] relay_lock;
      logic [5:0] free;
      logic       cfg_err;
   } psi_map_t;
   // Bus channel states
   typedef enum logic {PSI_WR_COLLECT, PSI_WR_RESP} psi_wr_state_t;
   typedef enum logic {PSI_RD_IDLE, PSI_RD_DATA} psi_rd_state_t;
endpackage : psi_pkg

// ---- verilog/psi_relay_count.sv ----
`timescale 1ns/1ps
`include "psi_defs.svh"
module psi_relay_count (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // Six relay output selections, five bits each
   input  wire logic [29:0] relay_sel_in,
   // Number of relays set to staging
   output logic      [2:0]  count_out
);
   logic [2:0] cnt_d;

   // Count selections equal to the staging code
   always_comb begin
      cnt_d = `PSI_CNT_ZERO;
      for (int i = 0; i < 6; i++) begin
         if (relay_sel_in[i*`PSI_RELAY_W +: `PSI_RELAY_W] == `PSI_RELAY_STAGE) begin
            cnt_d = cnt_d + 3'h1;
         end
      end
   end

   // Registered count
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         count_out <= `PSI_CNT_ZERO;
      end else begin
         count_out <= cnt_d;
      end
   end
endmodule : psi_relay_count

// ---- verilog/psi_mapper.sv ----
`timescale 1ns/1ps
`include "psi_defs.svh"
module psi_mapper (
   // Clock and reset
   input  wire logic              mclk_in,
   input  wire logic              rst_in,
   // Configuration
   input  wire logic [1:0]        sel_in,
   input  wire logic              rot_en_in,
   input  wire logic [2:0]        count_in,
   // Interlock inputs, high when command present
   input  wire logic [5:0]        di_in,
   // Registered mapping result
   output psi_pkg::psi_map_t      map_out
);
   psi_pkg::psi_map_t m;
   logic [3:0]        first;
   logic [3:0]        pos;

   // Assign inputs to speed motor and staging relays
   always_comb begin
      m = '0;
      m.free = `PSI_ALL_FREE;
      first = 4'h0;
      pos = 4'h0;
      case (sel_in)
         `PSI_SEL_OFF: begin
            m.free = `PSI_ALL_FREE;
         end
         `PSI_SEL_IN1, `PSI_SEL_IN2: begin
            first = (sel_in == `PSI_SEL_IN2) ? 4'h1 : 4'h0;
            if (rot_en_in ? (count_in == `PSI_CNT_ZERO ||
                             {1'b0, count_in} > {1'b0, `PSI_CNT_MAX} - first)
                          : ({1'b0, count_in} > {1'b0, `PSI_CNT_MAX} - first - 4'h1)) begin
               m.cfg_err = 1'b1;
            end else begin
               if (!rot_en_in) begin
                  m.speed_lock = ~di_in[first[2:0]];
                  m.free[first[2:0]] = 1'b0;
               end
               for (int j = 0; j < 6; j++) begin
                  pos = first + 4'(j) + (rot_en_in ? 4'h0 : 4'h1);
                  if (3'(j) < count_in) begin
                     m.relay_lock[j] = ~di_in[pos[2:0]];
                     m.free[pos[2:0]] = 1'b0;
                  end
               end
            end
         end
         default: begin
            m.cfg_err = 1'b1;
         end
      endcase
   end

   // Registered result
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         map_out <= '{speed_lock: 1'b0, relay_lock: 6'h00, free: `PSI_ALL_FREE,
                      cfg_err: 1'b0};
      end else begin
         map_out <= m;
      end
   end
endmodule : psi_mapper

// ---- verilog/psi_top.sv ----
// Overview of operation
// - Interlock active while its input reads low
// - Start refused under speed interlock; alarm 2015
// - Selection zero disables interlocks, frees inputs
// - Relay count: selections equal to 31
// - Rotation interval zero means rotation disabled
// - Input one: speed motor, then relays
// - Input one, rotation: relays from input one
// - Input two: speed motor, then relays
// - Input two, rotation: relays from input two
// - Switch contact open: relay motor treated off
// - Protective contact open: motor fault, stop
`timescale 1ns/1ps
`include "psi_defs.svh"
module psi_top (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   // AXI4-Lite write response
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   output logic [1:0]       s_axi_bresp_out,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   input  wire logic [7:0]  s_axi_araddr_in,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   // Interlock contacts and start command
   input  wire logic [5:0]  di_in,
   input  wire logic        start_cmd_in,
   // Staging side
   output logic             start_out,
   output logic             speed_lock_out,
   output logic [5:0]       relay_lock_out,
   output logic [5:0]       motor_off_out,
   output logic [6:0]       motor_fault_out,
   output logic             staging_lock_alarm_out,
   output logic             cfg_err_out,
   output logic             irq_out
);
   psi_pkg::psi_wr_state_t wr_state_q;
   psi_pkg::psi_rd_state_t rd_state_q;
   psi_pkg::psi_map_t      map;
   logic        aw_have_q, w_have_q, wr_go;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rd_word;
   logic [3:0]  wstrb_q;
   logic [1:0]  sel_q;
   logic [31:0] rot_int_q;
   logic [29:0] relay_sel_q;
   logic [6:0]  cause_q, fault_q;
   logic [2:0]  st_q, mask_q, st_set, st_clr, st_d, mask_d;
   logic [2:0]  cnt_q;
   logic [5:0]  di_q;
   logic        rot_en, cfg_err_q, alarm_q, refuse;

   // Byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Write channels: address and data taken in either order
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= `PSI_ZERO32;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            s_axi_awready_out <= 1'b0;
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
         end else if (wr_state_q == psi_pkg::PSI_WR_COLLECT && !aw_have_q) begin
            s_axi_awready_out <= 1'b1;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            s_axi_wready_out <= 1'b0;
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
         end else if (wr_state_q == psi_pkg::PSI_WR_COLLECT && !w_have_q) begin
            s_axi_wready_out <= 1'b1;
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
      end
   end

   assign wr_go = (wr_state_q == psi_pkg::PSI_WR_COLLECT) && aw_have_q && w_have_q;

   // Write response state machine
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wr_state_q <= psi_pkg::PSI_WR_COLLECT;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `PSI_RESP_OKAY;
      end else begin
         case (wr_state_q)
            psi_pkg::PSI_WR_COLLECT: begin
               if (wr_go) begin
                  wr_state_q <= psi_pkg::PSI_WR_RESP;
                  s_axi_bvalid_out <= 1'b1;
                  s_axi_bresp_out <= (awaddr_q > `PSI_A_ALARM || awaddr_q[1:0] != 2'h0)
                                     ? `PSI_RESP_ERR : `PSI_RESP_OKAY;
               end
            end
            psi_pkg::PSI_WR_RESP: begin
               if (s_axi_bready_in) begin
                  wr_state_q <= psi_pkg::PSI_WR_COLLECT;
                  s_axi_bvalid_out <= 1'b0;
               end
            end
            default: begin
               wr_state_q <= psi_pkg::PSI_WR_COLLECT;
            end
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sel_q <= `PSI_SEL_OFF;
         rot_int_q <= `PSI_ROT_OFF;
         relay_sel_q <= 30'h0000_0000;
         cause_q <= 7'h00;
      end else if (wr_go) begin
         case (awaddr_q)
            `PSI_A_SEL:   sel_q <= 2'(merge({30'h0000_0000, sel_q}, wdata_q, wstrb_q));
            `PSI_A_ROT:   rot_int_q <= merge(rot_int_q, wdata_q, wstrb_q);
            `PSI_A_RELAY: relay_sel_q <= 30'(merge({2'h0, relay_sel_q}, wdata_q, wstrb_q));
            `PSI_A_CAUSE: cause_q <= 7'(merge({25'h000_0000, cause_q}, wdata_q, wstrb_q));
            default: begin
            end
         endcase
      end
   end

   // Rotation state from the interval
   assign rot_en = (rot_int_q != `PSI_ROT_OFF);

   // Sampled contacts
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         di_q <= 6'h00;
      end else begin
         di_q <= di_in;
      end
   end

   psi_relay_count u_count (
      .mclk_in      (mclk_in),
      .rst_in       (rst_in),
      .relay_sel_in (relay_sel_q),
      .count_out    (cnt_q)
   );

   psi_mapper u_map (
      .mclk_in   (mclk_in),
      .rst_in    (rst_in),
      .sel_in    (sel_q),
      .rot_en_in (rot_en),
      .count_in  (cnt_q),
      .di_in     (di_q),
      .map_out   (map)
   );

   assign refuse = start_cmd_in && map.speed_lock;

   // Start gating and staging outputs
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         start_out <= 1'b0;
         speed_lock_out <= 1'b0;
         relay_lock_out <= 6'h00;
         motor_off_out <= 6'h00;
         fault_q <= 7'h00;
         cfg_err_q <= 1'b0;
      end else begin
         start_out <= start_cmd_in && !map.speed_lock;
         speed_lock_out <= map.speed_lock;
         relay_lock_out <= map.relay_lock;
         motor_off_out <= map.relay_lock & ~cause_q[6:1];
         fault_q <= {map.relay_lock, map.speed_lock} & cause_q;
         cfg_err_q <= map.cfg_err;
      end
   end

   assign motor_fault_out = fault_q;
   assign cfg_err_out = cfg_err_q;

   // Alarm held until the speed motor interlock clears
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         alarm_q <= 1'b0;
      end else if (refuse) begin
         alarm_q <= 1'b1;
      end else if (!map.speed_lock) begin
         alarm_q <= 1'b0;
      end
   end

   assign staging_lock_alarm_out = alarm_q;

   // Sticky events; a set beats a same-cycle clear
   always_comb begin
      st_set = 3'h0;
      st_set[`PSI_ST_REFUSED] = refuse;
      st_set[`PSI_ST_CFGERR] = map.cfg_err && !cfg_err_q;
      st_set[`PSI_ST_FAULT] = |({map.relay_lock, map.speed_lock} & cause_q & ~fault_q);
      st_clr = (wr_go && awaddr_q == `PSI_A_STATUS && wstrb_q[0]) ? wdata_q[2:0] : 3'h0;
      st_d = (st_q & ~st_clr) | st_set;
      mask_d = (wr_go && awaddr_q == `PSI_A_MASK && wstrb_q[0]) ? wdata_q[2:0] : mask_q;
   end

   // Status, mask and interrupt
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_q <= 3'h0;
         mask_q <= 3'h0;
         irq_out <= 1'b0;
      end else begin
         st_q <= st_d;
         mask_q <= mask_d;
         irq_out <= |(st_d & mask_d);
      end
   end

   // Read data selection
   always_comb begin
      case (s_axi_araddr_in)
         `PSI_A_SEL:    rd_word = {30'h0000_0000, sel_q};
         `PSI_A_ROT:    rd_word = rot_int_q;
         `PSI_A_RELAY:  rd_word = {2'h0, relay_sel_q};
         `PSI_A_CAUSE:  rd_word = {25'h000_0000, cause_q};
         `PSI_A_STATUS: rd_word = {29'h0000_0000, st_q};
         `PSI_A_MASK:   rd_word = {29'h0000_0000, mask_q};
         `PSI_A_STATE:  rd_word = {15'h0000, map.cfg_err, cnt_q, map.free,
                                   map.relay_lock, map.speed_lock};
         `PSI_A_ALARM:  rd_word = alarm_q ? `PSI_ALARM_CODE : `PSI_ZERO32;
         default:       rd_word = `PSI_ZERO32;
      endcase
   end

   // Read channel state machine
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rd_state_q <= psi_pkg::PSI_RD_IDLE;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= `PSI_ZERO32;
         s_axi_rresp_out <= `PSI_RESP_OKAY;
      end else begin
         case (rd_state_q)
            psi_pkg::PSI_RD_IDLE: begin
               s_axi_arready_out <= 1'b1;
               if (s_axi_arvalid_in && s_axi_arready_out) begin
                  rd_state_q <= psi_pkg::PSI_RD_DATA;
                  s_axi_arready_out <= 1'b0;
                  s_axi_rvalid_out <= 1'b1;
                  s_axi_rdata_out <= rd_word;
                  s_axi_rresp_out <= (s_axi_araddr_in > `PSI_A_ALARM ||
                                      s_axi_araddr_in[1:0] != 2'h0)
                                     ? `PSI_RESP_ERR : `PSI_RESP_OKAY;
               end
            end
            psi_pkg::PSI_RD_DATA: begin
               if (s_axi_rready_in) begin
                  rd_state_q <= psi_pkg::PSI_RD_IDLE;
                  s_axi_rvalid_out <= 1'b0;
                  s_axi_arready_out <= 1'b1;
               end
            end
            default: begin
               rd_state_q <= psi_pkg::PSI_RD_IDLE;
            end
         endcase
      end
   end

   // Checks on the interlock behaviour
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   AST_ACTIVE_LOW: assert property (
      $past(sel_q == `PSI_SEL_IN1 && !rot_en && cnt_q <= 3'h5 && di_q[0])
      |-> !map.speed_lock) else $error("speed interlock active with input high");
   AST_START_REFUSED: assert property (
      refuse |=> !start_out && alarm_q && st_q[`PSI_ST_REFUSED])
      else $error("start not refused under speed interlock");
   AST_START_PASSED: assert property (
      start_cmd_in && !map.speed_lock |=> start_out) else $error("start lost");
   AST_OFF_FREE: assert property (
      $past(sel_q == `PSI_SEL_OFF) |-> map.free == `PSI_ALL_FREE && !map.speed_lock
      && map.relay_lock == 6'h00) else $error("interlock active while disabled");
   AST_COUNT_ALL: assert property (
      (relay_sel_q == {6{`PSI_RELAY_STAGE}}) [*2] |-> cnt_q == `PSI_CNT_MAX)
      else $error("relay count wrong");
   AST_ROT_NO_SPEED: assert property (
      $past(rot_en) |-> !map.speed_lock) else $error("speed interlock under rotation");
   AST_IN1_SPEED: assert property (
      $past(sel_q == `PSI_SEL_IN1 && !rot_en && cnt_q <= 3'h5 && !di_q[0])
      |-> map.speed_lock && !map.free[0]) else $error("input one not speed motor");
   AST_IN1_ROT: assert property (
      $past(sel_q == `PSI_SEL_IN1 && rot_en && cnt_q != 3'h0 && !di_q[0])
      |-> map.relay_lock[0]) else $error("input one not first relay");
   AST_IN2_SPEED: assert property (
      $past(sel_q == `PSI_SEL_IN2 && !rot_en && cnt_q <= 3'h4 && !di_q[1])
      |-> map.speed_lock && map.free[0]) else $error("input two not speed motor");
   AST_IN2_ROT: assert property (
      $past(sel_q == `PSI_SEL_IN2 && rot_en && cnt_q != 3'h0 && cnt_q <= 3'h5 && !di_q[1])
      |-> map.relay_lock[0] && map.free[0]) else $error("input two not first relay");
   AST_SWITCH_OFF: assert property (
      map.relay_lock[0] && !cause_q[1] |=> motor_off_out[0] && !motor_fault_out[1])
      else $error("switched-off motor not reported");
   AST_FAULT_STOP: assert property (
      map.speed_lock && cause_q[0] && !fault_q[0] |=> motor_fault_out[0] && st_q[`PSI_ST_FAULT])
      else $error("protective trip not reported");
   AST_CFG_ERR: assert property (
      $past(sel_q == `PSI_SEL_IN1 && !rot_en && cnt_q == 3'h6)
      |-> map.cfg_err && map.relay_lock == 6'h00 ##1 cfg_err_out)
      else $error("disallowed mapping applied");
endmodule : psi_top

// ---- verif/psi_contact_model.sv ----
`timescale 1ns/1ps
module psi_contact_model (
   // Clock
   input  wire logic       mclk_in,
   // Contacts held open by the bench, bit i for input i+1
   input  wire logic [5:0] open_in,
   // Extra cycle of contact settling
   input  wire logic       slow_in,
   // Command lines, high while the contact is closed
   output logic      [5:0] di_out
);
   logic [5:0] line_q;

   // Closed contact gives command present, open drops it
   always_ff @(posedge mclk_in) begin
      line_q <= ~open_in;
      di_out <= slow_in ? line_q : ~open_in;
   end
endmodule : psi_contact_model

// ---- verif/psi_top_tb_top.sv ----
`timescale 1ns/1ps
`include "psi_defs.svh"
module psi_top_tb_top;
   // Bench drive
   logic        mclk_in, rst_in, awv, wv, bry, arv, rry, start, slow;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rel, v, e;
   logic [3:0]  ws;
   logic [5:0]  open;
   // Design answers
   logic        awr, wr, bv, arr, rv, start_o, spd_lk, alarm, cfg_err, irq;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rd;
   logic [5:0]  di, rly_lk, m_off;
   logic [6:0]  m_flt;
   int          num_errors, num_checks;

   psi_top psi_top_inst (
      .mclk_in(mclk_in), .rst_in(rst_in),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
      .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .di_in(di),
      .start_cmd_in(start), .start_out(start_o), .speed_lock_out(spd_lk),
      .relay_lock_out(rly_lk), .motor_off_out(m_off), .motor_fault_out(m_flt),
      .staging_lock_alarm_out(alarm), .cfg_err_out(cfg_err), .irq_out(irq)
   );

   psi_contact_model psi_contact_model_inst (
      .mclk_in(mclk_in), .open_in(open), .slow_in(slow), .di_out(di)
   );

   // Clock, 8 ns period
   always #4 mclk_in = ~mclk_in;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done

   // Bus write: address and data together, each released when taken
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 0;
      w_ok = 0;
      rs = 2'h3;
      @(posedge mclk_in);
      awv <= 1;
      awa <= a;
      wv <= 1;
      wd <= d;
      bry <= 1;
      while (n < 200) begin
         @(posedge mclk_in);
         n++;
         if (!aw_ok && awr) begin
            awv <= 0;
            aw_ok = 1;
         end
         if (!w_ok && wr) begin
            wv <= 0;
            w_ok = 1;
         end
         if (bv) begin
            bry <= 0;
            rs = bresp;
            n = 1000;
         end
      end
      if (n < 1000) check(32'h0000_0000, 32'h0000_0001, "write hang");
   endtask : wr_reg

   // Bus read
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge mclk_in);
      arv <= 1;
      ara <= a;
      rry <= 1;
      while (n < 200) begin
         @(posedge mclk_in);
         n++;
         if (arr) arv <= 0;
         if (rv) begin
            rry <= 0;
            d = rd;
            rs = rresp;
            n = 1000;
         end
      end
      if (n < 1000) check(32'h0000_0000, 32'h0000_0001, "read hang");
   endtask : rd_reg

   // Selection, rotation and relay count, then let the map settle
   task automatic cfg(input int s, input int rt, input int n);
      for (int i = 0; i < 6; i++) begin
         rel[i*5 +: 5] = (i < n) ? 5'h1F : 5'h1E;
      end
      wr_reg(`PSI_A_RELAY, rel, r);
      wr_reg(`PSI_A_ROT, (rt != 0) ? 32'h8000_0000 : 32'h0000_0000, r);
      wr_reg(`PSI_A_SEL, 32'(s), r);
      repeat (8) @(posedge mclk_in);
   endtask : cfg

   // Expected STATE with every contact open
   function automatic logic [31:0] exp_state(input int s, input int rt, input int n);
      int f;
      int k;
      logic [31:0] x;
      f = (s == 1) ? 0 : 1;
      k = n + ((rt == 0) ? 1 : 0);
      x = 32'h0000_0000;
      x[15:13] = n[2:0];
      if (s == 3 || (rt != 0 && n == 0) || f + k > 6) begin
         x[16] = 1'b1;
      end else begin
         x[0] = (rt == 0);
         x[6:1] = 6'h3F >> (6 - n);
         x[12:7] = ~((6'h3F >> (6 - k)) << f);
      end
      return x;
   endfunction : exp_state

   // Watchdog
   initial begin
      repeat (30000) @(posedge mclk_in);
      check(32'h0000_0000, 32'h0000_0001, "watchdog expired");
      summarize();
   end

   // Test sequence
   initial begin
      num_errors = 0;
      num_checks = 0;
      mclk_in = 0;
      rst_in = 1;
      {awv, wv, bry, arv, rry, start, slow} = 7'h00;
      awa = 8'h00;
      ara = 8'h00;
      wd = 32'h0000_0000;
      rel = 32'h0000_0000;
      ws = 4'hF;
      open = 6'h3F;
      repeat (4) @(posedge mclk_in);
      rst_in <= 0;
      rd_reg(`PSI_A_STATE, v, r);
      check(v, 32'h0000_1F80, "state after reset");
      rd_reg(8'h20, v, r);
      check({30'h0000_0000, r}, 32'h0000_0002, "unmapped read resp");
      check(v, 32'h0000_0000, "unmapped read data");
      wr_reg(8'h24, 32'h0000_0001, r);
      check({30'h0000_0000, r}, 32'h0000_0002, "unmapped write resp");
      done("reset");
      // Selections one to three, every rotation state and relay count
      for (int s = 1; s < 4; s++) begin
         for (int rt = 0; rt < 2; rt++) begin
            for (int n = 0; n < 7; n++) begin
               cfg(s, rt, n);
               rd_reg(`PSI_A_STATE, v, r);
               e = exp_state(s, rt, n);
               v = v & (e[16] ? 32'h0001_E07F : 32'h0001_FFFF);
               check(v, e, "mapping");
               check({31'h0000_0000, cfg_err}, {31'h0000_0000, e[16]}, "cfg flag");
            end
         end
      end
      done("mapping");
      // Closed contacts release every interlock
      cfg(1, 0, 2);
      open <= 6'h00;
      repeat (8) @(posedge mclk_in);
      check({25'h000_0000, rly_lk, spd_lk}, 32'h0000_0000, "locks closed");
      done("polarity");
      // Start refused under speed interlock, slow contacts
      slow <= 1;
      open <= 6'h01;
      wr_reg(`PSI_A_MASK, 32'h0000_0001, r);
      repeat (8) @(posedge mclk_in);
      check({31'h0000_0000, spd_lk}, 32'h0000_0001, "speed lock");
      @(posedge mclk_in);
      start <= 1;
      @(posedge mclk_in);
      start <= 0;
      #1;
      check({30'h0000_0000, start_o, alarm}, 32'h0000_0001, "refused start");
      rd_reg(`PSI_A_ALARM, v, r);
      check(v, 32'h0000_07DF, "alarm code");
      rd_reg(`PSI_A_STATUS, v, r);
      check(v & 32'h0000_0001, 32'h0000_0001, "refused status");
      check(v & 32'h0000_0002, 32'h0000_0002, "cfg error status");
      check({31'h0000_0000, irq}, 32'h0000_0001, "irq raised");
      wr_reg(`PSI_A_STATUS, 32'h0000_0001, r);
      @(posedge mclk_in);
      check({31'h0000_0000, irq}, 32'h0000_0000, "irq cleared");
      open <= 6'h00;
      repeat (8) @(posedge mclk_in);
      rd_reg(`PSI_A_ALARM, v, r);
      check(v, 32'h0000_0000, "alarm released");
      @(posedge mclk_in);
      start <= 1;
      @(posedge mclk_in);
      start <= 0;
      #1;
      check({31'h0000_0000, start_o}, 32'h0000_0001, "start accepted");
      slow <= 0;
      done("start");
      // Switch contact versus protective contact on relays
      wr_reg(`PSI_A_CAUSE, 32'h0000_0005, r);
      open <= 6'h07;
      repeat (8) @(posedge mclk_in);
      check({26'h000_0000, m_off}, 32'h0000_0001, "motor off");
      check({25'h000_0000, m_flt}, 32'h0000_0005, "motor fault");
      rd_reg(`PSI_A_STATUS, v, r);
      check(v & 32'h0000_0004, 32'h0000_0004, "fault status");
      wr_reg(`PSI_A_MASK, 32'h0000_0004, r);
      @(posedge mclk_in);
      check({31'h0000_0000, irq}, 32'h0000_0001, "irq on fault");
      wr_reg(`PSI_A_MASK, 32'h0000_0000, r);
      @(posedge mclk_in);
      check({31'h0000_0000, irq}, 32'h0000_0000, "irq masked");
      done("contacts");
      // Interlocks off, every contact opened first
      open <= 6'h3F;
      cfg(0, 0, 2);
      rd_reg(`PSI_A_STATE, v, r);
      check(v & 32'h0001_1FFF, 32'h0000_1F80, "interlocks off");
      done("disable");
      summarize();
   end
endmodule : psi_top_tb_top
